//--- dv/icc_host_model.sv
// host register master issuing command cycles
`timescale 1ns/1ns
`default_nettype none
module icc_host_model (
  // clock and read data
  input wire logic clk_sys,
  input wire logic [31:0] rdData,
  // register port
  output var icc_pkg::icc_bus_t bus
);
  import icc_pkg::*;
  // idle port at time zero
  initial bus = '0;
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0}; // released lines flip
  endtask : wr
  // read strobe, data taken in the following cycle
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '{addr: ~a, wdata: 32'hFFFFFFFF, wr: 1'b0, rd: 1'b0};
    #1 d = rdData;
  endtask : rd
endmodule : icc_host_model
`default_nettype wire

//--- dv/icc_illum_cal_checker.sv
// port assertions for the illumination command handler
`timescale 1ns/1ns
`default_nettype none
`include "icc_defs.svh"
module icc_illum_cal_checker #(
  parameter logic [15:0] NUM_DUTY = 16'h0010
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // observed ports
  input wire icc_pkg::icc_bus_t bus,
  input wire logic [31:0] rdData,
  input wire logic [15:0] dutyIndex,
  input wire logic [10:0][15:0] maxDrive,
  input wire logic calBypass
);
  import icc_pkg::*;
  logic execWr;
  logic stRd;
  // decoded strobes
  assign execWr = bus.wr && (bus.addr == `ICC_ADDR_EXEC);
  assign stRd = bus.rd && (bus.addr == `ICC_ADDR_STATUS);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////
  cal_sticky_a: assert property (calBypass |=> calBypass)
    else $error("bypass mode dropped");
  bypass_cause_a: assert property ($rose(calBypass) |-> $past(execWr) || $past(execWr, 2))
    else $error("bypass set without command");
  drive_cause_a: assert property (!$past(srst) && $changed(maxDrive) |->
    $past(execWr) || $past(execWr, 2)) else $error("ceiling moved without command");
  duty_cause_a: assert property (!$past(srst) && $changed(dutyIndex) |->
    $past(execWr) || $past(execWr, 2)) else $error("index moved without command");
  drive_alone_a: assert property (!$past(srst) && $changed(maxDrive) |-> $stable(dutyIndex))
    else $error("ceiling and index moved together");
  idx_range_a: assert property (dutyIndex < NUM_DUTY)
    else $error("index beyond table");
  rd_hold_a: assert property (!bus.rd |=> $stable(rdData))
    else $error("read data moved without read");
  stat_mode_a: assert property (stRd && $past(calBypass) |=> rdData[`ICC_ST_CAL_BIT])
    else $error("status hides bypass mode");
  unmapped_zero_a: assert property (bus.rd && bus.addr > `ICC_ADDR_STATUS |=> rdData == 32'h0)
    else $error("unmapped read not zero");
  // main scenarios
  cover property ($rose(calBypass));
  cover property (execWr ##1 stRd);
  cover property ($changed(dutyIndex));
endmodule : icc_illum_cal_checker
`default_nettype wire

//--- dv/icc_illum_cal_tb_top.sv
// self-checking bench for the illumination command handler
`timescale 1ns/1ns
`default_nettype none
`include "icc_defs.svh"
module icc_illum_cal_tb_top;
  import icc_pkg::*;
  localparam logic [15:0] NDUTY = 16'h000C;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  icc_bus_t bus;
  logic [31:0] rdData;
  icc_sensor_t sensorNow = '0;
  icc_duty_t dutyNow = '0;
  logic [15:0] dutyIndex;
  logic [10:0][15:0] maxDrive;
  logic [10:0][15:0] mdExp;
  logic calBypass;
  int miscompares = 0;
  int checked = 0;
  int k;
  logic [31:0] seed = 32'h00016587;
  logic [31:0] d;
  logic [7:0] prm [0:22];
  logic [7:0] rep [0:21];
  logic [175:0] rec;
  // free-running clock
  always #5 clk_sys = ~clk_sys;
  icc_illum_cal #(.NUM_DUTY(NDUTY)) dut (.clk_sys(clk_sys), .srst(srst), .bus(bus),
    .rdData(rdData), .sensorNow(sensorNow), .dutyNow(dutyNow), .dutyIndex(dutyIndex),
    .maxDrive(maxDrive), .calBypass(calBypass));
  icc_host_model host (.clk_sys(clk_sys), .rdData(rdData), .bus(bus));
  ////////////////////////////////////////////////////////////////
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // expected byte i of a field sent low byte first
  function logic [31:0] byt(input logic [175:0] v, input int i);
    return {24'h0, v[i*8 +: 8]};
  endfunction : byt
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // command, n parameters, expected refusal, m reply bytes popped
  task run(input logic [8:0] cmd, input int n, input logic bad, input int m);
    host.wr(`ICC_ADDR_CMD, {23'h0, cmd});
    for (int j = 0; j < n; j++) host.wr(`ICC_ADDR_PARAM, {24'h0, prm[j]});
    host.wr(`ICC_ADDR_EXEC, 32'h0);
    host.rd(`ICC_ADDR_STATUS, d);
    chk({31'h0, d[`ICC_ST_ERR_BIT]}, {31'h0, bad});
    if (!bad) chk({27'h0, d[12:8]}, 32'(m));
    for (int j = 0; j < m; j++) begin
      host.rd(`ICC_ADDR_REPLY, d);
      rep[j] = d[7:0];
    end
  endtask : run
  task end_of_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // hang guard
  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    d = rnd();
    sensorNow <= {rnd(), rnd(), rnd()};
    dutyNow <= {rnd(), rnd(), rnd(), d[15:0]};
    for (k = 0; k < 11; k++) begin
      d = rnd();
      mdExp[k] = d[15:0];
      prm[0] = 8'(k);
      prm[1] = d[7:0];
      prm[2] = d[15:8];
      run({1'b0, `ICC_OP_MAX_DRIVE}, 3, 1'b0, 0);
    end
    for (k = 0; k < 11; k++) begin
      prm[0] = 8'(k);
      run({1'b1, `ICC_OP_MAX_DRIVE}, 1, 1'b0, 2);
      chk({16'h0, rep[1], rep[0]}, {16'h0, mdExp[k]});
    end
    prm[0] = 8'h0B;
    run({1'b0, `ICC_OP_MAX_DRIVE}, 3, 1'b1, 0);
    chk({31'h0, maxDrive === mdExp}, 32'h1);
    run({1'b1, `ICC_OP_SENSOR}, 0, 1'b0, 12);
    for (k = 0; k < 12; k++) chk({24'h0, rep[k]}, byt({80'h0, sensorNow}, k));
    prm[0] = 8'(NDUTY - 16'h1);
    prm[1] = 8'h00;
    run({1'b0, `ICC_OP_DUTY_IDX}, 2, 1'b0, 0);
    prm[0] = 8'(NDUTY);
    run({1'b0, `ICC_OP_DUTY_IDX}, 2, 1'b1, 0);
    chk({16'h0, dutyIndex}, {16'h0, NDUTY - 16'h1});
    run({1'b1, `ICC_OP_DUTY_IDX}, 0, 1'b0, 18);
    rec = {32'h0, dutyNow, NDUTY - 16'h1, NDUTY};
    for (k = 0; k < 18; k++) chk({24'h0, rep[k]}, byt(rec, k));
    d = rnd();
    prm[0] = {6'h0, d[1:0] == 2'h3 ? 2'h2 : d[1:0]};
    for (k = 1; k < 23; k++) begin
      d = rnd();
      prm[k] = d[7:0];
      rec[(k-1)*8 +: 8] = d[7:0];
    end
    run({1'b0, `ICC_OP_CAL_OVR}, 23, 1'b0, 0);
    run({1'b1, `ICC_OP_CAL_REC}, 1, 1'b0, 22);
    for (k = 0; k < 22; k++) chk({24'h0, rep[k]}, byt(rec, k));
    prm[0] = (prm[0] == 8'h02) ? 8'h00 : prm[0] + 8'h01;
    run({1'b1, `ICC_OP_CAL_REC}, 1, 1'b0, 22);
    for (k = 0; k < 22; k++) chk({24'h0, rep[k]}, 32'h0);
    prm[0] = 8'h03;
    run({1'b1, `ICC_OP_CAL_REC}, 1, 1'b1, 0);
    run({1'b0, `ICC_OP_CAL_OVR}, 23, 1'b1, 0);
    // record write form refused even with thirty parameter bytes
    host.wr(`ICC_ADDR_CMD, {23'h0, 1'b0, `ICC_OP_CAL_REC});
    for (k = 0; k < 30; k++) host.wr(`ICC_ADDR_PARAM, 32'h0);
    host.wr(`ICC_ADDR_EXEC, 32'h0);
    host.rd(`ICC_ADDR_STATUS, d);
    chk({31'h0, d[`ICC_ST_ERR_BIT]}, 32'h1);
    for (k = 0; k < 3; k++) begin
      prm[0] = (k == 1) ? 8'h01 : 8'h00;
      run({1'b0, `ICC_OP_CAL_MODE}, 1, 1'b0, 0);
      run({1'b1, `ICC_OP_CAL_MODE}, 0, 1'b0, 1);
      chk({24'h0, rep[0]}, (k > 0) ? 32'h1 : 32'h0);
      chk({31'h0, calBypass}, (k > 0) ? 32'h1 : 32'h0);
    end
    // second execute without a fresh command is refused
    host.wr(`ICC_ADDR_EXEC, 32'h0);
    host.rd(`ICC_ADDR_STATUS, d);
    chk({31'h0, d[`ICC_ST_ERR_BIT]}, 32'h1);
    host.rd(8'h40, d);
    chk(d, 32'h0);
    @(posedge clk_sys);
    srst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    #1 chk({31'h0, calBypass}, 32'h0);
    end_of_test();
  end
endmodule : icc_illum_cal_tb_top
bind icc_illum_cal icc_illum_cal_checker #(.NUM_DUTY(NUM_DUTY)) chk_i (.clk_sys(clk_sys),
  .srst(srst), .bus(bus), .rdData(rdData), .dutyIndex(dutyIndex), .maxDrive(maxDrive),
  .calBypass(calBypass));
`default_nettype wire

//--- logic/icc_defs.svh
// constants for the illumination and calibration command handler
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH
// opcodes
`define ICC_OP_CAL_REC 8'hC6
`define ICC_OP_SENSOR 8'hCD
`define ICC_OP_MAX_DRIVE 8'hCE
`define ICC_OP_DUTY_IDX 8'hCF
`define ICC_OP_CAL_MODE 8'hD1
`define ICC_OP_CAL_OVR 8'hD2
// register byte addresses
`define ICC_ADDR_CMD 8'h00
`define ICC_ADDR_PARAM 8'h04
`define ICC_ADDR_EXEC 8'h08
`define ICC_ADDR_REPLY 8'h0C
`define ICC_ADDR_STATUS 8'h10
// command register fields
`define ICC_CMD_READ_BIT 8
// status register fields
`define ICC_ST_ERR_BIT 0
`define ICC_ST_CAL_BIT 1
`define ICC_ST_LOAD_BIT 2
`define ICC_ST_LEFT_LSB 8
// sizes and counts
`define ICC_REC_BYTES 5'h16
`define ICC_PARAM_MAX 5'h17
`define ICC_CNT_SAT 5'h1F
`define ICC_NEED_NONE 5'h1E
`define ICC_LED_CODES 8'h03
`define ICC_DRIVE_CODES 8'h0B
`define ICC_SENSOR_BYTES 5'h0C
`define ICC_DUTY_BYTES 5'h12
`define ICC_DRIVE_BYTES 5'h02
`define ICC_MODE_BYTES 5'h01
`define ICC_CAL_ENABLE 8'h01
`endif

//--- logic/icc_illum_cal.sv
// illumination and calibration command handler with host register port
//
// Behaviour
// - calibration record opcode C6h, read takes colour
// - record read selector byte names LED colour
// - record reply x, y, luminance, sensors, duty
// - sensor query CDh returns twelve bytes RGB
// - drive write CEh stores colour ceiling
// - drive colour selector codes zero to ten
// - drive read returns stored two-byte level
// - duty index write CFh selects entry
// - duty read: count, index, seven duty cycles
// - mode command D1h, value one enables
// - calibration mode bypasses all image processing
// - calibration mode cleared only by restart
// - mode read returns one enable byte
// - override write replaces whole colour record
// - override opcode D2h, same destination
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "icc_defs.svh"

module icc_illum_cal #(
  parameter logic [15:0] NUM_DUTY = 16'h0010
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // host register port
  input wire icc_pkg::icc_bus_t bus,
  output logic [31:0] rdData,
  // illumination side
  input wire icc_pkg::icc_sensor_t sensorNow,
  input wire icc_pkg::icc_duty_t dutyNow,
  output logic [15:0] dutyIndex,
  output logic [10:0][15:0] maxDrive,
  // video path
  output logic calBypass
);
  import icc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // parameter byte count each command form expects
  function automatic logic [4:0] paramNeed(input logic [7:0] op, input logic rd);
    logic [4:0] n;
    n = `ICC_NEED_NONE;
    case (op)
      `ICC_OP_CAL_REC: n = rd ? 5'h01 : `ICC_NEED_NONE;
      `ICC_OP_SENSOR: n = rd ? 5'h00 : `ICC_NEED_NONE;
      `ICC_OP_MAX_DRIVE: n = rd ? 5'h01 : 5'h03;
      `ICC_OP_DUTY_IDX: n = rd ? 5'h00 : 5'h02;
      `ICC_OP_CAL_MODE: n = rd ? 5'h00 : 5'h01;
      `ICC_OP_CAL_OVR: n = rd ? `ICC_NEED_NONE : `ICC_PARAM_MAX;
      default: n = `ICC_NEED_NONE;
    endcase
    return n;
  endfunction : paramNeed

  // colour selector inside its defined range
  function automatic logic selOk(input logic [7:0] sel, input logic [7:0] codes);
    return sel < codes;
  endfunction : selOk

  ////////////////////////////////////////////////////////////////////////////
  // state

  icc_phase_t phase_r;
  logic [7:0] opcode_r;
  logic readForm_r;
  logic [7:0] paramMem [0:22];
  logic [4:0] paramCnt_r;
  logic [7:0] replyMem [0:21];
  logic [4:0] replyLen_r;
  logic [4:0] replyPtr_r;
  logic err_r;
  logic calMode_r;
  logic [7:0] calMem [0:2][0:21];
  logic [10:0][15:0] drive_r;
  logic [15:0] dutyIdx_r;
  logic [31:0] rdData_r;

  // port strobes
  logic wrCmd, wrParam, wrExec, rdReply;
  assign wrCmd = bus.wr && (bus.addr == `ICC_ADDR_CMD);
  assign wrParam = bus.wr && (bus.addr == `ICC_ADDR_PARAM);
  assign wrExec = bus.wr && (bus.addr == `ICC_ADDR_EXEC);
  assign rdReply = bus.rd && (bus.addr == `ICC_ADDR_REPLY);

  ////////////////////////////////////////////////////////////////////////////
  // command evaluation

  logic accept;
  logic [7:0] replyNxt [0:21];
  logic [4:0] replyLen_nxt;
  logic [7:0] sel;
  logic [15:0] idxParam;
  logic [95:0] sensorVec;
  logic [143:0] dutyVec;

  assign sensorVec = {sensorNow.blue, sensorNow.green, sensorNow.red};
  assign dutyVec = {dutyNow, dutyIdx_r, NUM_DUTY};
  assign sel = paramMem[0];
  assign idxParam = {paramMem[1], paramMem[0]};

  // decide acceptance and build the reply
  always_comb begin
    accept = 1'b0;
    replyLen_nxt = 5'h00;
    for (int i = 0; i < 22; i++) begin
      replyNxt[i] = 8'h00;
    end
    // unsupported forms carry an out-of-use count and must never match it
    if (phase_r == PH_LOAD && paramCnt_r == paramNeed(opcode_r, readForm_r) &&
        paramNeed(opcode_r, readForm_r) != `ICC_NEED_NONE) begin
      case (opcode_r)
        `ICC_OP_CAL_REC: begin
          if (selOk(sel, `ICC_LED_CODES)) begin
            accept = 1'b1;
            replyLen_nxt = `ICC_REC_BYTES;
            for (int i = 0; i < 22; i++) begin
              replyNxt[i] = calMem[sel[1:0]][i];
            end
          end
        end
        `ICC_OP_SENSOR: begin
          accept = 1'b1;
          replyLen_nxt = `ICC_SENSOR_BYTES;
          for (int i = 0; i < 12; i++) begin
            replyNxt[i] = sensorVec[8 * i +: 8];
          end
        end
        `ICC_OP_MAX_DRIVE: begin
          if (selOk(sel, `ICC_DRIVE_CODES)) begin
            accept = 1'b1;
            if (readForm_r) begin
              replyLen_nxt = `ICC_DRIVE_BYTES;
              replyNxt[0] = drive_r[sel[3:0]][7:0];
              replyNxt[1] = drive_r[sel[3:0]][15:8];
            end
          end
        end
        `ICC_OP_DUTY_IDX: begin
          if (readForm_r) begin
            accept = 1'b1;
            replyLen_nxt = `ICC_DUTY_BYTES;
            for (int i = 0; i < 18; i++) begin
              replyNxt[i] = dutyVec[8 * i +: 8];
            end
          end else begin
            accept = idxParam < NUM_DUTY;
          end
        end
        `ICC_OP_CAL_MODE: begin
          accept = 1'b1;
          if (readForm_r) begin
            replyLen_nxt = `ICC_MODE_BYTES;
            replyNxt[0] = {7'h00, calMode_r};
          end
        end
        `ICC_OP_CAL_OVR: begin
          accept = selOk(sel, `ICC_LED_CODES);
        end
        default: accept = 1'b0;
      endcase
    end
  end

  logic doExec;
  assign doExec = wrExec && accept;

  ////////////////////////////////////////////////////////////////////////////
  // command capture and phase

  // opcode latch and phase sequencing
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase_r <= PH_IDLE;
      opcode_r <= 8'h00;
      readForm_r <= 1'b0;
    end else if (wrCmd) begin
      phase_r <= PH_LOAD;
      opcode_r <= bus.wdata[7:0];
      readForm_r <= bus.wdata[`ICC_CMD_READ_BIT];
    end else if (wrExec) begin
      phase_r <= (doExec && replyLen_nxt != 5'h00) ? PH_REPLY : PH_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      paramCnt_r <= 5'h00;
      for (int i = 0; i < 23; i++) begin
        paramMem[i] <= 8'h00;
      end
    end else if (wrCmd) begin
      paramCnt_r <= 5'h00;
    end else if (wrParam && phase_r == PH_LOAD) begin
      if (paramCnt_r < `ICC_PARAM_MAX) begin
        paramMem[paramCnt_r] <= bus.wdata[7:0];
      end
      if (paramCnt_r != `ICC_CNT_SAT) begin
        paramCnt_r <= paramCnt_r + 5'h01;
      end
    end
  end

  // rejection flag, cleared by the next command
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      err_r <= 1'b0;
    end else if (wrExec) begin
      err_r <= ~accept;
    end else if (wrCmd) begin
      err_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stored state

  // calibration records, three colours
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int c = 0; c < 3; c++) begin
        for (int i = 0; i < 22; i++) begin
          calMem[c][i] <= 8'h00;
        end
      end
    end else if (doExec && opcode_r == `ICC_OP_CAL_OVR) begin
      for (int i = 0; i < 22; i++) begin
        calMem[sel[1:0]][i] <= paramMem[i + 1];
      end
    end
  end

  // drive ceilings
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      drive_r <= '0;
    end else if (doExec && opcode_r == `ICC_OP_MAX_DRIVE && !readForm_r) begin
      drive_r[sel[3:0]] <= {paramMem[2], paramMem[1]};
    end
  end

  // duty cycle index
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dutyIdx_r <= 16'h0000;
    end else if (doExec && opcode_r == `ICC_OP_DUTY_IDX && !readForm_r) begin
      dutyIdx_r <= idxParam;
    end
  end

  // calibration bypass latch
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      calMode_r <= 1'b0;
    end else if (doExec && opcode_r == `ICC_OP_CAL_MODE && !readForm_r) begin
      if (sel == `ICC_CAL_ENABLE) begin
        calMode_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply buffer and read port

  // reply capture and pop pointer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      replyLen_r <= 5'h00;
      replyPtr_r <= 5'h00;
      for (int i = 0; i < 22; i++) begin
        replyMem[i] <= 8'h00;
      end
    end else if (wrCmd) begin
      replyLen_r <= 5'h00;
      replyPtr_r <= 5'h00;
    end else if (doExec) begin
      replyLen_r <= replyLen_nxt;
      replyPtr_r <= 5'h00;
      for (int i = 0; i < 22; i++) begin
        replyMem[i] <= replyNxt[i];
      end
    end else if (rdReply && replyPtr_r < replyLen_r) begin
      replyPtr_r <= replyPtr_r + 5'h01;
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdData_r <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdData_r <= 32'h0000_0000;
      case (bus.addr)
        `ICC_ADDR_CMD: rdData_r <= {23'h000000, readForm_r, opcode_r};
        `ICC_ADDR_REPLY: begin
          if (replyPtr_r < replyLen_r) begin
            rdData_r <= {24'h000000, replyMem[replyPtr_r]};
          end
        end
        `ICC_ADDR_STATUS: begin
          rdData_r[`ICC_ST_ERR_BIT] <= err_r;
          rdData_r[`ICC_ST_CAL_BIT] <= calMode_r;
          rdData_r[`ICC_ST_LOAD_BIT] <= phase_r == PH_LOAD;
          rdData_r[`ICC_ST_LEFT_LSB +: 5] <= replyLen_r - replyPtr_r;
        end
        default: rdData_r <= 32'h0000_0000;
      endcase
    end
  end

  // outputs straight from flip-flops
  assign rdData = rdData_r;
  assign dutyIndex = dutyIdx_r;
  assign maxDrive = drive_r;
  assign calBypass = calMode_r;

endmodule : icc_illum_cal
`default_nettype wire

//--- logic/icc_pkg.sv
// types shared by the illumination and calibration command handler
`default_nettype none
package icc_pkg;
  // host register port
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } icc_bus_t;
  // integrating sensor outputs
  typedef struct packed {
    logic [31:0] blue;
    logic [31:0] green;
    logic [31:0] red;
  } icc_sensor_t;
  // current duty cycles, u8.8 each
  typedef struct packed {
    logic [15:0] white;
    logic [15:0] magenta;
    logic [15:0] cyan;
    logic [15:0] yellow;
    logic [15:0] blue;
    logic [15:0] green;
    logic [15:0] red;
  } icc_duty_t;
  // command phase
  typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_REPLY} icc_phase_t;
endpackage : icc_pkg
`default_nettype wire
